// ==== hw/jkms_ff.sv ====
/*
 Synchronous JK master-slave flip-flop with true and complement
 outputs, trigger, J/K triggering and two active-low set inputs.
 Assumes all inputs synchronous to i_mclk; set inputs idle high.
*/
// Behaviour
// [R1] Trigger rising captures J and K into the master.
// [R2] Trigger falling moves the master result onto both outputs.
// [R3] JK: both toggle, J sets, K clears, neither holds.
// [R4] Trigger high: J falling sets, K falling clears the outputs.
// [R5] Trigger high: J and K falling together invert the outputs.
// [R6] Preset low sets, clear low clears, both high hold.
// [R7] Active set inputs override trigger, J and K at once.
// [R8] Both set inputs low: earlier one wins; simultaneous undefined.
// [R9] Driver keeps set inputs high while triggering.
// [R10] Only sampled levels matter, never edge rates.
// [R11] Set inputs active low, idle high.
// [R12] Inputs sampled each clock; transitions by sample comparison.
`timescale 1ns/10ps
`default_nettype none
`include "jkms_consts.svh"
module jkms_ff (
   input  wire logic i_mclk,
   input  wire logic i_rst,
   input  wire logic i_trigger,
   input  wire logic i_j,
   input  wire logic i_k,
   input  wire logic i_preset_low_input_n,
   input  wire logic i_clear_low_input_n,
   output var  logic o_true_output,
   output var  logic o_complement_output
);
   import jkms_pkg::*;

   logic [4:0] cur;
   logic [4:0] fall;
   logic [4:0] rise;
   logic       trg;
   logic       jv;
   logic       kv;
   logic       pre_act;
   logic       clr_act;
   logic       true_reg;
   logic       true_next;
   logic       comp_reg;
   logic       comp_next;
   logic       mst_reg;
   logic       mst_next;
   logic       first_reg;
   logic       first_next;
   jkms_act_t  act;

   // One sampler for all five inputs, levels only
   jkms_edge #(
      .WIDTH   (5),
      .RST_VAL (`JKMS_RST_SAMPLE)
   ) u_edge (
      .i_mclk    (i_mclk),
      .i_rst     (i_rst),
      .i_raw     ({i_trigger, i_j, i_k,
                   i_preset_low_input_n, i_clear_low_input_n}),
      .o_cur     (cur),
      .o_fall    (fall),
      .o_rise    (rise)
   );

   assign trg     = cur[4];
   assign jv      = cur[3];
   assign kv      = cur[2];
   assign pre_act = ~cur[1];   // R11
   assign clr_act = ~cur[0];   // R11

   // JK result for the master bit from J, K and current output
   function automatic logic jk_eval(input logic j, input logic k,
                                    input logic q);
      jk_eval = (j & ~q) | (~k & q);   // R3
   endfunction : jk_eval

   // Pick the action; set inputs first, since they override
   always_comb begin
      act        = JKMS_HOLD;
      first_next = first_reg;
      if (pre_act && clr_act) begin
         // The input low alone last cycle is the earlier one; a tie
         // keeps the old winner, a true tie being undefined anyway
         act = first_reg ? JKMS_SET : JKMS_CLEAR;   // R8
      end else if (pre_act) begin
         act        = JKMS_SET;   // R6 R7
         first_next = 1'b1;
      end else if (clr_act) begin
         act        = JKMS_CLEAR;   // R6 R7
         first_next = 1'b0;
      end else if (fall[4]) begin
         act = JKMS_LOAD;   // R2
      end else if (trg && fall[3] && fall[2]) begin
         act = JKMS_TOGGLE;   // R5
      end else if (trg && fall[3]) begin
         act = JKMS_SET;   // R4
      end else if (trg && fall[2]) begin
         act = JKMS_CLEAR;   // R4
      end
   end

   // Master captures on trigger rise; slave follows the action
   always_comb begin
      mst_next = mst_reg;
      if (rise[4]) mst_next = jk_eval(jv, kv, true_reg);   // R1
      true_next = true_reg;
      case (act)
         JKMS_SET:    true_next = 1'b1;
         JKMS_CLEAR:  true_next = 1'b0;
         JKMS_TOGGLE: true_next = ~true_reg;
         JKMS_LOAD:   true_next = mst_reg;   // R2 R3
         default:     true_next = true_reg;
      endcase
      comp_next = ~true_next;
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         true_reg  <= `JKMS_RST_TRUE;
         comp_reg  <= ~`JKMS_RST_TRUE;
         mst_reg   <= `JKMS_RST_MASTER;
         first_reg <= 1'b0;
      end else begin
         true_reg  <= true_next;
         comp_reg  <= comp_next;
         mst_reg   <= mst_next;
         first_reg <= first_next;
      end
   end

   // Outputs straight from flip-flops
   assign o_true_output       = true_reg;
   assign o_complement_output = comp_reg;

   // The checks below see sampled levels, one clock after the pins;
   // each action then lands in the output register one clock later,
   // so consequents are written one cycle after their cause, except in the R8 and R12 checks.

   // Trigger fall with the set inputs idle
   sequence trig_fall_s;
      fall[4] && cur[1] && cur[0];
   endsequence

   // J alone falls while the trigger is high and sets are idle
   sequence j_fall_s;
      trg && fall[3] && !fall[2] && cur[1] && cur[0];
   endsequence

   // K alone falls while the trigger is high and sets are idle
   sequence k_fall_s;
      trg && fall[2] && !fall[3] && cur[1] && cur[0];
   endsequence

   // J and K fall together under the same conditions
   sequence jk_fall_s;
      trg && fall[3] && fall[2] && cur[1] && cur[0];
   endsequence

   // Both set inputs low for two cycles running
   sequence both_low_s;
      (pre_act && clr_act) [*2];
   endsequence

   // Slave takes the master bit on the trigger fall
   property load_p;
      @(posedge i_mclk) disable iff (i_rst)
         trig_fall_s |=> true_reg == $past(mst_reg);
   endproperty

   // Master stage: captured on trigger rise, held otherwise
   capture_master_a: assert property (@(posedge i_mclk)   // R1
      disable iff (i_rst) rise[4] |=> mst_reg == $past(jk_eval(jv, kv,
      true_reg))) else $error("master not captured");
   master_hold_a: assert property (@(posedge i_mclk)   // R1
      disable iff (i_rst) !rise[4] |=> $stable(mst_reg))
      else $error("master changed without trigger rise");
   slave_update_a: assert property (load_p)   // R2
      else $error("slave did not load master");
   outputs_compl_a: assert property (@(posedge i_mclk)   // R2
      disable iff (i_rst) comp_reg == ~true_reg)
      else $error("outputs not complementary");

   // J and K triggering, only while the trigger is high
   j_fall_set_a: assert property (@(posedge i_mclk)   // R4
      disable iff (i_rst) j_fall_s |=> true_reg)
      else $error("J fall did not set");
   k_fall_clear_a: assert property (@(posedge i_mclk)   // R4
      disable iff (i_rst) k_fall_s |=> !true_reg)
      else $error("K fall did not clear");
   trig_low_ignore_a: assert property (@(posedge i_mclk)   // R4
      disable iff (i_rst) (!trg && !fall[4] && (fall[3] || fall[2]) &&
      cur[1] && cur[0]) |=> $stable(true_reg))
      else $error("J or K fall acted with trigger low");
   jk_toggle_a: assert property (@(posedge i_mclk)   // R5
      disable iff (i_rst) jk_fall_s |=> true_reg != $past(true_reg))
      else $error("no toggle");

   // Set inputs override everything else
   preset_wins_a: assert property (@(posedge i_mclk)   // R6
      disable iff (i_rst) (pre_act && !clr_act) |=> true_reg)
      else $error("preset lost");
   clear_wins_a: assert property (@(posedge i_mclk)   // R7
      disable iff (i_rst) (clr_act && !pre_act) |=> !true_reg)
      else $error("clear lost");
   first_low_a: assert property (@(posedge i_mclk)   // R8
      disable iff (i_rst) (pre_act && !clr_act) ##1 both_low_s |-> true_reg)
      else $error("earlier preset did not win");
   clear_first_a: assert property (@(posedge i_mclk)   // R8
      disable iff (i_rst) (clr_act && !pre_act) ##1 both_low_s |-> !true_reg)
      else $error("earlier clear did not win");

   // Nothing moves the outputs without a qualifying level change
   idle_hold_a: assert property (@(posedge i_mclk)   // R10
      disable iff (i_rst)
      (cur[1] && cur[0] && !fall[4] && !(trg && (fall[3] || fall[2])))
      |=> $stable(true_reg)) else $error("spurious change");

   // Samples track the pins one clock late, except just after reset
   sample_track_a: assert property (@(posedge i_mclk)   // R12
      disable iff (i_rst) !$past(i_rst) |-> cur == $past({i_trigger,
      i_j, i_k, i_preset_low_input_n, i_clear_low_input_n}))
      else $error("input sample stale");
endmodule : jkms_ff
`default_nettype wire

// ==== common/jkms_consts.svh ====
/*
 Constants for the synchronous JK master-slave flip-flop.
 Assumes inclusion by bare name from any design file.
*/
`ifndef JKMS_CONSTS_SVH
`define JKMS_CONSTS_SVH
`define JKMS_RST_TRUE   1'b0
`define JKMS_RST_MASTER 1'b0
// Sampler reset: trigger, J and K idle low, both set inputs idle high
`define JKMS_RST_SAMPLE 5'h03
`define JKMS_SYNC_DEPTH 2
`endif

// ==== common/jkms_pkg.sv ====
/*
 Types for the synchronous JK master-slave flip-flop.
 Assumes no surroundings beyond the compile order.
*/
`default_nettype none
package jkms_pkg;
   // Action chosen for the output stage in a cycle
   typedef enum logic [2:0] {
      JKMS_HOLD,
      JKMS_SET,
      JKMS_CLEAR,
      JKMS_TOGGLE,
      JKMS_LOAD
   } jkms_act_t;
endpackage : jkms_pkg
`default_nettype wire

// ==== hw/jkms_edge.sv ====
/*
 Input sampler: registers each input once and keeps the previous
 sample, so the top can see level transitions.
 Assumes inputs synchronous to i_mclk.
*/
`timescale 1ns/10ps
`default_nettype none
module jkms_edge #(
   parameter int               WIDTH   = 5,
   parameter logic [WIDTH-1:0] RST_VAL = '1
) (
   input  wire logic             i_mclk,
   input  wire logic             i_rst,
   input  wire logic [WIDTH-1:0] i_raw,
   output var  logic [WIDTH-1:0] o_cur,
   output var  logic [WIDTH-1:0] o_fall,
   output var  logic [WIDTH-1:0] o_rise
);
   logic [WIDTH-1:0] cur_reg;
   logic [WIDTH-1:0] cur_next;
   logic [WIDTH-1:0] prv_reg;
   logic [WIDTH-1:0] prv_next;

   // Elaboration check: an empty sampler has nothing to compare
   if (WIDTH < 1) begin : g_bad_width
      $error("jkms_edge: WIDTH must be at least 1");
   end

   // Sample now and one cycle back
   always_comb begin
      cur_next = i_raw;   // R10 R12
      prv_next = cur_reg;
   end

   // Reset to each pin's idle level, else a false edge follows reset
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         cur_reg <= RST_VAL;
         prv_reg <= RST_VAL;
      end else begin
         cur_reg <= cur_next;
         prv_reg <= prv_next;
      end
   end

   // Transitions by sample comparison
   assign o_cur  = cur_reg;
   assign o_fall = prv_reg & ~cur_reg;   // R12
   assign o_rise = ~prv_reg & cur_reg;   // R12
endmodule : jkms_edge
`default_nettype wire

// ==== tb/jkms_gates.sv ====
/*
 Partner model: the gate logic that drives the flip-flop inputs.
 Assumes one-cycle go pulses from the bench, changes after posedge.
*/
`timescale 1ns/10ps
`default_nettype none
module jkms_gates (
   input  wire logic       i_mclk,
   input  wire logic       i_go,
   input  wire logic [2:0] i_op,
   output var  logic       o_trigger,
   output var  logic       o_j,
   output var  logic       o_k,
   output var  logic       o_pre_n,
   output var  logic       o_clr_n
);
   // Idle levels: sets inactive high, trigger and data low
   initial begin
      o_trigger = 1'b0;
      o_j = 1'b0;
      o_k = 1'b0;
      o_pre_n = 1'b1;
      o_clr_n = 1'b1;
   end
   // One input group changes per command
   always @(posedge i_mclk) begin
      if (i_go) begin
         case (i_op)
            3'h0: o_trigger <= ~o_trigger;
            3'h1: o_j <= ~o_j;
            3'h2: o_k <= ~o_k;
            3'h3: begin
               o_j <= ~o_j;
               o_k <= ~o_k;
            end
            3'h4: o_pre_n <= 1'b0;
            3'h5: o_clr_n <= 1'b0;
            default: begin
               o_pre_n <= 1'b1;
               o_clr_n <= 1'b1;
            end
         endcase
      end
   end
endmodule : jkms_gates
`default_nettype wire

// ==== tb/jkms_ff_tb.sv ====
/*
 Self-checking bench: random input steps against an integer model.
 Assumes the gate partner and a 2-edge output latency.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== 1'(e)) begin \
   fails++; $display("wrong value %s exp %0d got %0b", nm, e, g); end end
module jkms_ff_tb;
   logic       i_mclk = 1'b0;
   logic       i_rst = 1'b1;
   logic       go = 1'b0;
   logic [2:0] op = 3'h0;
   logic       t, j, k, pn, cn, qt, qc;
   int         fails = 0, checked = 0, cyc = 0, n, sel;
   int         mt = 0, mj = 0, mk = 0, mp = 1, mc = 1, mq = 0, mm = 0;
   jkms_gates i_jkms_gates (.i_mclk(i_mclk), .i_go(go), .i_op(op),
      .o_trigger(t), .o_j(j), .o_k(k), .o_pre_n(pn), .o_clr_n(cn));
   jkms_ff i_jkms_ff (.i_mclk(i_mclk), .i_rst(i_rst), .i_trigger(t),
      .i_j(j), .i_k(k), .i_preset_low_input_n(pn),
      .i_clear_low_input_n(cn), .o_true_output(qt),
      .o_complement_output(qc));
   // 20 MHz clock
   initial begin
      forever #25 i_mclk = ~i_mclk;
   end
   // Hang guard sized well above the planned run
   always @(posedge i_mclk) begin
      cyc++;
      if (cyc == 30000) begin
         fails++;
         test_done();
      end
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : test_done
   // One command, model update, then look once the output has settled
   task automatic step(input int c);
      int jf, kf;
      go <= 1'b1;
      op <= 3'(c);
      @(posedge i_mclk);
      go <= 1'b0;
      jf = (c == 1 || c == 3) && mj;
      kf = (c == 2 || c == 3) && mk;
      case (c)
         0: begin
            mt = 1 - mt;
            if (mt == 1) mm = mj ? (mk ? 1 - mq : 1) : (mk ? 0 : mq);
            else mq = mm;
         end
         1, 2, 3: begin
            if (c != 2) mj = 1 - mj;
            if (c != 1) mk = 1 - mk;
            if (mt == 1 && jf && kf) mq = 1 - mq;
            else if (mt == 1 && jf) mq = 1;
            else if (mt == 1 && kf) mq = 0;
         end
         4: begin
            if (mc == 1) mq = 1;
            mp = 0;
         end
         5: begin
            if (mp == 1) mq = 0;
            mc = 0;
         end
         default: begin
            mp = 1;
            mc = 1;
         end
      endcase
      repeat (4) @(posedge i_mclk);
      #1;
      `CHK("true output", mq, qt)
      `CHK("complement output", 1 - mq, qc)
   endtask : step
   initial begin
      void'($urandom(32'h8db4fad0));
      repeat (16) @(posedge i_mclk);
      i_rst <= 1'b0;
      repeat (4) @(posedge i_mclk);
      #1;
      `CHK("reset true output", 0, qt)
      `CHK("reset complement output", 1, qc)
      for (n = 0; n < 400; n++) begin
         sel = $urandom % 8;
         if (sel < 4) step(sel);
         else begin
            // Sets always released before any further triggering
            if (sel != 5) step(sel == 7 ? 5 : 4);
            if (sel != 4) step(sel == 7 ? 4 : 5);
            step(6);
         end
      end
      test_done();
   end
endmodule : jkms_ff_tb
`default_nettype wire
